// ### design/ccd_eval_pkg.sv
// Functional notes
// - exposure settings 6 and 7 give the tabled microsecond times per mode
// - interlaced scanning applies no electronic shutter; exposure setting ignored
// - single or dual output chosen by inverting right/left phase-2 drives
// - reset, transfer and sample pulses are AND/OR of 2.5 ns delay taps
// - row and column counters count in Gray code
// - counters live apart from the counter-free unit forming hclk and sampling
// - offset loop holds dark converter code at 4080
// - pixel data is presented inverted at the output
// - black-level strobe covers the central 10 dark-reference columns
// - under strobe, code differing from 4080 drives buffers to lower or raise
// - offset monitoring sits in a unit apart from the timing generator
// - offset correction applied once every non-dumped line time
// - optional mode accumulates error and corrects once per frame
// - fast dump discards 256 lines, reads 512, discards 240
// - interlaced scanning never performs fast line dumping
`default_nettype none
package ccd_eval_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int US_PS = 1000000;
    localparam int CYC_PER_US = US_PS / CLK_PERIOD_PS;
    localparam int TAP_STEP_PS = 2500;
    localparam int TAP_N = 8;
    localparam int CW = 11;
    localparam int AW = 12;
    localparam int NCH = 2;
    // ----------------------------------------
    // frame geometry
    // ----------------------------------------
    localparam logic [CW-1:0] COLS_TOTAL = 11'h404;
    localparam logic [CW-1:0] DUMP_HEAD = 11'h100;
    localparam logic [CW-1:0] READ_ROWS = 11'h200;
    localparam logic [CW-1:0] DUMP_TAIL = 11'h0f0;
    localparam logic [CW-1:0] ROWS_TOTAL = DUMP_HEAD + READ_ROWS + DUMP_TAIL;
    localparam logic [CW-1:0] H_BLANK = 11'h014;
    localparam logic [CW-1:0] BLK_COL_FIRST = 11'h007;
    localparam logic [CW-1:0] BLK_COLS = 11'h00a;
    localparam logic [5:0] BLK_STROBE_CYC = 6'h14;
    localparam logic [AW-1:0] BLACK_CODE = 12'hff0;
    localparam logic [3:0] CORR_CYC = 4'h8;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam int ST_COL_LSB = 0;
    localparam int ST_ROW_LSB = 11;
    localparam int ST_DUMP_BIT = 24;
    localparam int ST_HGATE_BIT = 25;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // ctrl word, msb first: frame_offset, expo[2:0], interlaced, dual, fast_dump, run
    typedef struct packed {
        logic frame_offset;
        logic [2:0] expo;
        logic interlaced;
        logic dual;
        logic fast_dump;
        logic run;
    } mode_t;
    // exposure in us, column {fast_dump, dual}
    localparam logic [15:0] EXPO_US [8][4] = '{
        '{16'h8214, 16'h5078, 16'h5078, 16'h3750},
        '{16'h4010, 16'h27b0, 16'h1770, 16'h1130},
        '{16'h1f18, 16'h1360, 16'h0bb8, 16'h09ec},
        '{16'h0e9c, 16'h0910, 16'h0744, 16'h0730},
        '{16'h0650, 16'h03f8, 16'h06a4, 16'h06a4},
        '{16'h0234, 16'h016a, 16'h0338, 16'h0338},
        '{16'h012a, 16'h00c6, 16'h01cc, 16'h01cc},
        '{16'h0044, 16'h0037, 16'h005d, 16'h005d}};

    function automatic logic [CW-1:0] gray2bin(input logic [CW-1:0] g);
        logic [CW-1:0] b;
        b[CW-1] = g[CW-1];
        for (int i = CW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    function automatic logic [CW-1:0] gray_inc(input logic [CW-1:0] g);
        logic [CW-1:0] b;
        b = gray2bin(g) + 1'b1;
        return b ^ (b >> 1);
    endfunction
endpackage
`default_nettype wire

// ### design/ccd_eval_timing.sv
// The placing of the registers and register access over APB were left to the implementer.
`default_nettype none
// ----------------------------------------
// counter unit: every row/column counter lives here
// ----------------------------------------
module ccd_counter_unit #(
    parameter int CYC_PER_US_P = ccd_eval_pkg::CYC_PER_US
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire ccd_eval_pkg::mode_t mode,
    output logic shutter,
    output logic xfer_gate,
    output logic vshift,
    output logic hgate,
    output logic dump_line,
    output logic black_level_strobe,
    output logic frame_end,
    output logic [ccd_eval_pkg::CW-1:0] row_g,
    output logic [ccd_eval_pkg::CW-1:0] col_g
);
    import ccd_eval_pkg::*;
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXPOSE = 2'b01, ST_XFER = 2'b10, ST_READ = 2'b11} seq_t;
    seq_t state, next_state;
    logic [CW-1:0] row_b, col_b, act_cols, line_len;
    logic [15:0] expo_us, us_cnt, pre_cnt;
    logic [5:0] stb_len;
    logic fd_eff, row_dump, line_done, frame_done, us_tick, expo_done, pix_tick;
    logic next_hgate, next_strobe;

    // mode decode and position compare
    assign fd_eff = mode.fast_dump & ~mode.interlaced;
    assign expo_us = EXPO_US[mode.expo][{mode.fast_dump, mode.dual}];
    assign row_b = gray2bin(row_g);
    assign col_b = gray2bin(col_g);
    assign row_dump = fd_eff && (row_b < DUMP_HEAD || row_b >= DUMP_HEAD + READ_ROWS);
    assign act_cols = mode.dual ? (COLS_TOTAL >> 1) : COLS_TOTAL;
    // dumped lines skip horizontal readout, only the blank interval remains
    assign line_len = row_dump ? H_BLANK : act_cols + H_BLANK;
    assign line_done = pix_tick && col_b == line_len - 1'b1;
    assign frame_done = line_done && row_b == ROWS_TOTAL - 1'b1;
    assign us_tick = pre_cnt == 16'(CYC_PER_US_P - 1);
    assign expo_done = us_tick && us_cnt == expo_us - 1'b1;
    assign next_hgate = next_state == ST_READ && state == ST_READ && !row_dump && col_b < act_cols;
    assign next_strobe = state == ST_READ && !row_dump
        && col_b >= BLK_COL_FIRST && col_b < BLK_COL_FIRST + BLK_COLS;

    // frame sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (mode.run) next_state = mode.interlaced ? ST_XFER : ST_EXPOSE;
            ST_EXPOSE: if (expo_done) next_state = ST_XFER;
            ST_XFER: next_state = ST_READ;
            ST_READ: if (frame_done) next_state = ST_IDLE;
        endcase
    end

    // sequencer and exposure timers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            pre_cnt <= '0;
            us_cnt <= '0;
        end else if (ce) begin
            state <= next_state;
            pre_cnt <= (state != ST_EXPOSE || us_tick) ? '0 : pre_cnt + 1'b1;
            us_cnt <= (state != ST_EXPOSE) ? '0 : us_cnt + 16'(us_tick);
        end
    end

    // gray counters: one bit flips per step, quieter for hclk and sampling
    always_ff @(posedge clk_sys) begin
        if (!rst_n || (ce && state != ST_READ)) begin
            pix_tick <= 1'b0;
            row_g <= '0;
            col_g <= '0;
        end else if (ce) begin
            pix_tick <= ~pix_tick;
            if (pix_tick) col_g <= line_done ? '0 : gray_inc(col_g);
            if (line_done) row_g <= gray_inc(row_g);
        end
    end

    // registered strobes to the sensor and the other units
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            {shutter, xfer_gate, vshift, hgate, dump_line, black_level_strobe, frame_end} <= '0;
        end else if (ce) begin
            shutter <= state == ST_IDLE && next_state == ST_EXPOSE;
            xfer_gate <= state == ST_XFER;
            vshift <= line_done;
            hgate <= next_hgate;
            dump_line <= state == ST_READ && row_dump;
            black_level_strobe <= next_strobe;
            frame_end <= frame_done;
        end
    end

    // strobe length helper for checking
    always_ff @(posedge clk_sys) begin
        if (!rst_n) stb_len <= '0;
        else if (ce) stb_len <= black_level_strobe ? stb_len + 1'b1 : '0;
    end

    AST_EXPO_SET6: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode.expo == 3'h6 && !mode.fast_dump && !mode.dual |-> expo_us == 16'h012a)
        else $error("setting 6 single output not 298 us");
    AST_EXPO_SET7: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode.expo == 3'h7 && mode.fast_dump && mode.dual |-> expo_us == 16'h005d)
        else $error("setting 7 dump dual not 93 us");
    AST_NO_SHUTTER_IL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && state == ST_IDLE && mode.run && mode.interlaced |=> state == ST_XFER && !shutter)
        else $error("shutter used in interlaced mode");
    AST_GRAY_STEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(col_g) && col_g != '0 |-> $countones(col_g ^ $past(col_g)) == 1)
        else $error("column counter not gray");
    AST_DUMP_HEAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && state == ST_READ && fd_eff && row_b < DUMP_HEAD |=> dump_line && !hgate)
        else $error("head line not dumped");
    AST_IL_NO_DUMP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode.interlaced && $past(mode.interlaced) |-> !dump_line)
        else $error("dump in interlaced mode");
    AST_STROBE_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && black_level_strobe && !next_strobe |-> stb_len == BLK_STROBE_CYC - 1'b1)
        else $error("strobe not ten columns long");
    COV_STROBE: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(black_level_strobe));
    COV_FRAME: cover property (@(posedge clk_sys) disable iff (!rst_n) frame_end && mode.fast_dump);
endmodule

// ----------------------------------------
// hclk/sampling unit: no counters, only edges
// ----------------------------------------
module ccd_hclk_unit (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic hgate,
    input wire logic dual,
    input wire logic [ccd_eval_pkg::TAP_N-1:0] taps,
    output logic hclk_phase1,
    output logic hclk_phase2_right,
    output logic hclk_phase2_left,
    output logic reset_pulse,
    output logic charge_xfer_pulse,
    output logic sample_pulse_a,
    output logic sample_pulse_b
);
    import ccd_eval_pkg::*;
    logic gate_q, next_h1;

    assign next_h1 = hgate ? ~hclk_phase1 : 1'b0;

    // horizontal phases; left phase inverted for single output
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            {gate_q, hclk_phase1, hclk_phase2_left} <= '0;
            hclk_phase2_right <= 1'b1;
        end else if (ce) begin
            gate_q <= hgate;
            hclk_phase1 <= next_h1;
            hclk_phase2_right <= ~next_h1;
            hclk_phase2_left <= dual ? ~next_h1 : next_h1;
        end
    end

    // pulses are tap products, sub-cycle: cannot come from a flip-flop
    assign reset_pulse = gate_q & hclk_phase1 & taps[0] & ~taps[1];
    assign charge_xfer_pulse = gate_q & hclk_phase1 & taps[2] & ~taps[3];
    assign sample_pulse_a = gate_q & hclk_phase1 & (taps[4] | taps[5]) & ~taps[7];
    assign sample_pulse_b = gate_q & ~hclk_phase1 & (taps[4] | taps[5]) & ~taps[7];

    AST_H2_MODE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce |=> (hclk_phase2_left == hclk_phase2_right) == $past(dual))
        else $error("phase-2 inversion wrong for output mode");
    AST_CDS_GATED: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !gate_q |-> !(reset_pulse | charge_xfer_pulse | sample_pulse_a | sample_pulse_b))
        else $error("sampling pulse outside readout");
endmodule

// ----------------------------------------
// offset unit: kept apart so data toggling stays off sensor clocks
// ----------------------------------------
module ccd_offset_unit (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [ccd_eval_pkg::NCH*ccd_eval_pkg::AW-1:0] adc,
    input wire logic strobe,
    input wire logic frame_end,
    input wire logic per_frame,
    output logic [ccd_eval_pkg::NCH-1:0] buf_oe,
    output logic [ccd_eval_pkg::NCH-1:0] buf_raise
);
    import ccd_eval_pkg::*;
    for (genvar gi = 0; gi < NCH; gi++) begin : g_ch
        logic signed [15:0] acc;
        logic [3:0] run_cnt;
        logic [AW-1:0] code;
        logic over, under;
        assign code = adc[gi*AW +: AW];
        assign over = strobe && code > BLACK_CODE;
        assign under = strobe && code < BLACK_CODE;

        // per-line mode drives under strobe; frame mode sums, then drives once
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                acc <= '0;
                run_cnt <= '0;
                buf_oe[gi] <= 1'b0;
                buf_raise[gi] <= 1'b0;
            end else if (ce && !per_frame) begin
                acc <= '0;
                run_cnt <= '0;
                buf_oe[gi] <= over | under;
                buf_raise[gi] <= under;
            end else if (ce && frame_end) begin
                acc <= '0;
                run_cnt <= (acc != 0) ? CORR_CYC : '0;
                buf_oe[gi] <= acc != 0;
                buf_raise[gi] <= acc > 0;
            end else if (ce) begin
                acc <= acc + 16'(under) - 16'(over);
                run_cnt <= (run_cnt != 0) ? run_cnt - 1'b1 : '0;
                buf_oe[gi] <= run_cnt > 4'h1;
            end
        end

        AST_OFFSET_LOWER: assert property (@(posedge clk_sys) disable iff (!rst_n)
            ce && !per_frame && over |=> buf_oe[gi] && !buf_raise[gi])
            else $error("bright black code not lowered");
        AST_OFFSET_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
            ce && !per_frame && (!strobe || code == BLACK_CODE) |=> !buf_oe[gi])
            else $error("buffers on while offset correct");
        AST_FRAME_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n)
            ce && per_frame && !frame_end && run_cnt == 0 && $past(per_frame) |=> !buf_oe[gi])
            else $error("frame mode corrected mid-frame");
        COV_BUF: cover property (@(posedge clk_sys) disable iff (!rst_n) buf_oe[gi] && buf_raise[gi]);
    end
endmodule

// ----------------------------------------
// top: apb registers, converter input, pixel output
// ----------------------------------------
module ccd_eval_timing #(
    parameter int CYC_PER_US_P = ccd_eval_pkg::CYC_PER_US
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ccd_eval_pkg::TAP_N-1:0] taps,
    input wire logic [ccd_eval_pkg::NCH*ccd_eval_pkg::AW-1:0] adc_in,
    output logic [ccd_eval_pkg::NCH*ccd_eval_pkg::AW-1:0] pix_data,
    output logic shutter,
    output logic xfer_gate,
    output logic vshift,
    output logic fast_line_dump,
    output logic hclk_phase1,
    output logic hclk_phase2_right,
    output logic hclk_phase2_left,
    output logic reset_pulse,
    output logic charge_xfer_pulse,
    output logic sample_pulse_a,
    output logic sample_pulse_b,
    output logic [ccd_eval_pkg::NCH-1:0] offset_buf_oe,
    output logic [ccd_eval_pkg::NCH-1:0] offset_raise
);
    import ccd_eval_pkg::*;
    mode_t mode;
    logic [NCH*AW-1:0] adc_m, adc_s;
    logic [CW-1:0] row_g, col_g;
    logic hgate, strobe, frame_end;
    logic sel_ctrl, sel_stat, setup, wr_ctrl;
    logic [31:0] rd_word;

    // apb decode, one wait-free access cycle
    assign sel_ctrl = paddr == ADDR_CTRL;
    assign sel_stat = paddr == ADDR_STATUS;
    assign setup = psel & ~penable;
    assign wr_ctrl = psel & penable & pready & pwrite & sel_ctrl;
    assign rd_word = sel_ctrl ? {24'h00_0000, mode}
        : sel_stat ? {6'h00, hgate, fast_line_dump, 2'h0, row_g, col_g} : 32'h0000_0000;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            {pready, pslverr, prdata} <= '0;
            mode <= CTRL_RESET;
        end else if (ce) begin
            pready <= setup;
            pslverr <= setup & ~(sel_ctrl | sel_stat);
            prdata <= setup ? rd_word : prdata;
            if (wr_ctrl) mode <= pwdata[7:0];
        end
    end

    // converter pins: two-stage sync, then inverted to the connector
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            {adc_m, adc_s, pix_data} <= '0;
        end else if (ce) begin
            adc_m <= adc_in;
            adc_s <= adc_m;
            pix_data <= ~adc_s;
        end
    end

    ccd_counter_unit #(.CYC_PER_US_P(CYC_PER_US_P)) u_cnt (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .mode(mode),
        .shutter(shutter), .xfer_gate(xfer_gate), .vshift(vshift), .hgate(hgate),
        .dump_line(fast_line_dump), .black_level_strobe(strobe), .frame_end(frame_end),
        .row_g(row_g), .col_g(col_g)
    );

    ccd_hclk_unit u_hclk (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .hgate(hgate), .dual(mode.dual), .taps(taps),
        .hclk_phase1(hclk_phase1), .hclk_phase2_right(hclk_phase2_right),
        .hclk_phase2_left(hclk_phase2_left), .reset_pulse(reset_pulse),
        .charge_xfer_pulse(charge_xfer_pulse), .sample_pulse_a(sample_pulse_a),
        .sample_pulse_b(sample_pulse_b)
    );

    ccd_offset_unit u_ofs (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .adc(adc_s), .strobe(strobe),
        .frame_end(frame_end), .per_frame(mode.frame_offset),
        .buf_oe(offset_buf_oe), .buf_raise(offset_raise)
    );

    AST_PIX_INVERT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce |=> pix_data == ~$past(adc_s))
        else $error("pixel data not inverted");
    COV_APB_WR: cover property (@(posedge clk_sys) disable iff (!rst_n) wr_ctrl);
endmodule
`default_nettype wire

// ### bench/ccd_sensor_model.sv
`default_nettype none
// ----------------------------------------
// far side: delay line, converters, offset integrators
// ----------------------------------------
module ccd_sensor_model (
    input wire logic clk_sys,
    input wire logic load,
    input wire logic [11:0] code0,
    input wire logic [11:0] code1,
    input wire logic [1:0] oe,
    input wire logic [1:0] raise,
    output logic [7:0] taps,
    output logic [23:0] adc_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] code [2];
    logic [1:0] oe_q;
    // tapped delay line of the system clock
    for (genvar i = 0; i < 8; i++) begin : g_tap
        assign #(2.5 * i) taps[i] = clk_sys;
    end
    // one code step per enable burst; a slow loop, so no overshoot from sync delay
    always_ff @(posedge clk_sys) begin
        oe_q <= oe;
        for (int c = 0; c < 2; c++) begin
            if (load) begin
                code[c] <= (c == 1) ? code1 : code0;
            end else if (oe[c] && !oe_q[c]) begin
                code[c] <= raise[c] ? code[c] + 12'h001 : code[c] - 12'h001;
            end
        end
    end
    assign adc_in = {code[1], code[0]};
endmodule
`default_nettype wire

// ### bench/ccd_eval_timing_and_black_offset_tb_top.sv
`default_nettype none
module ccd_eval_timing_and_black_offset_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import ccd_eval_pkg::*;
    // short microsecond so exposures stay cheap to simulate
    localparam int CPU = 2;
    localparam int LINE_DUAL = 1068;
    localparam int EXP_US [2][4] = '{'{298, 198, 460, 460}, '{68, 55, 93, 93}};
    logic clk_sys = 0, rst_n = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, load = 1;
    logic [11:0] paddr = '0, code0 = 12'hff0, code1 = 12'hff0;
    logic [31:0] pwdata = '0, prdata, rd, w;
    logic pready, pslverr, err, shutter, xfer_gate, vshift, fast_line_dump, flag;
    logic hclk_phase1, hclk_phase2_right, hclk_phase2_left;
    logic reset_pulse, charge_xfer_pulse, sample_pulse_a, sample_pulse_b;
    logic [7:0] taps;
    logic [23:0] adc_in, pix_data;
    logic [1:0] offset_buf_oe, offset_raise;
    int fails = 0, compares = 0, cycles = 0, seed = 32'h0ff4, n, d;
    ccd_eval_timing #(.CYC_PER_US_P(CPU)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .taps(taps), .adc_in(adc_in), .pix_data(pix_data), .shutter(shutter),
        .xfer_gate(xfer_gate), .vshift(vshift), .fast_line_dump(fast_line_dump), .hclk_phase1(hclk_phase1),
        .hclk_phase2_right(hclk_phase2_right), .hclk_phase2_left(hclk_phase2_left), .reset_pulse(reset_pulse),
        .charge_xfer_pulse(charge_xfer_pulse), .sample_pulse_a(sample_pulse_a), .sample_pulse_b(sample_pulse_b),
        .offset_buf_oe(offset_buf_oe),
        .offset_raise(offset_raise));
    ccd_sensor_model model (.clk_sys(clk_sys), .load(load), .code0(code0), .code1(code1), .oe(offset_buf_oe),
        .raise(offset_raise), .taps(taps), .adc_in(adc_in));
    // ----------------------------------------
    // clock, timeout, checking helpers
    // ----------------------------------------
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            $display("[ERR] %0t run did not finish", $time);
            final_report();
        end
    end
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        chk32({31'h0, got}, {31'h0, exp}, what);
    endtask
    // apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, dat};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic restart();
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
    endtask
    function automatic int expo_cycles(input int e, input int m);
        return EXP_US[e-6][m] * CPU;
    endfunction
    // per cycle: phase-2 pairing and offset direction; returns enabled samples
    task automatic watch(input int cyc, input logic dual, input logic [1:0] up, output int oes);
        oes = 0;
        repeat (cyc) begin
            @(posedge clk_sys);
            chk1(hclk_phase2_left, dual ? hclk_phase2_right : ~hclk_phase2_right, "phase2 pairing");
            chk1(hclk_phase2_right, ~hclk_phase1, "phase2 against phase1");
            for (int c = 0; c < 2; c++) begin
                if (offset_buf_oe[c] === 1'b1) begin
                    oes++;
                    chk1(offset_raise[c], up[c], "offset direction");
                end
            end
        end
    endtask
    task automatic final_report();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        apb(1'b0, ADDR_CTRL, '0);
        chk32(rd, 32'h0000_0000, "ctrl reset value");
        chk1(hclk_phase2_right, 1'b1, "phase2 idle level");
        // random ctrl words (run kept off) and random converter codes
        for (int i = 0; i < 6; i++) begin
            w = $random(seed) & 32'h0000_00fe;
            apb(1'b1, ADDR_CTRL, w);
            apb(1'b0, ADDR_CTRL, '0);
            chk32(rd, w, "ctrl readback");
            {code0, code1} <= 24'($random(seed));
            repeat (6) @(posedge clk_sys);
            chk32({8'h00, pix_data}, {8'h00, ~adc_in}, "pixel inversion");
            chk32({28'h000_0000, reset_pulse, charge_xfer_pulse, sample_pulse_a, sample_pulse_b}, 32'h0000_0000,
                "pulses outside readout");
        end
        apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
        apb(1'b0, 12'h008, '0);
        chk1(err, 1'b1, "unmapped error");
        apb(1'b1, 12'h00c, 32'h0000_00ff);
        apb(1'b0, ADDR_CTRL, '0);
        chk32(rd, w, "ctrl untouched");
        // clock enable low must freeze the converter path even while codes move
        ce <= 1'b0;
        {code0, code1} <= ~{code0, code1};
        @(posedge clk_sys);
        rd = {8'h00, pix_data};
        repeat (4) @(posedge clk_sys);
        chk32({8'h00, pix_data}, rd, "frozen by clock enable");
        ce <= 1'b1;
        $display("test registers done");
        // every exposure mode of settings 6 and 7
        for (int e = 6; e < 8; e++) begin
            for (int m = 0; m < 4; m++) begin
                restart();
                apb(1'b1, ADDR_CTRL, 32'((e << 4) | ((m & 1) << 2) | ((m >> 1) << 1) | 1));
                @(posedge clk_sys iff shutter === 1'b1);
                d = 0;
                do begin
                    @(posedge clk_sys);
                    d++;
                end while (xfer_gate !== 1'b1);
                chk1(d >= expo_cycles(e, m) - 1 && d <= expo_cycles(e, m) + 1, 1'b1, "exposure");
            end
        end
        $display("test exposure done");
        {code0, code1} <= {12'hff0, 12'hff0};
        restart();
        apb(1'b1, ADDR_CTRL, 32'h0000_007b);
        flag = 1'b0;
        do begin
            @(posedge clk_sys);
            flag |= shutter;
        end while (xfer_gate !== 1'b1);
        chk1(flag, 1'b0, "shutter in interlaced");
        flag = 1'b0;
        repeat (3000) begin
            @(posedge clk_sys);
            flag |= fast_line_dump;
        end
        chk1(flag, 1'b0, "dump in interlaced");
        $display("test interlaced done");
        restart();
        apb(1'b1, ADDR_CTRL, 32'h0000_0073);
        @(posedge clk_sys iff xfer_gate === 1'b1);
        n = 0;
        flag = 1'b0;
        do begin
            @(posedge clk_sys);
            n += int'(vshift);
            flag |= fast_line_dump;
        end while (!(flag && fast_line_dump === 1'b0));
        chk32(32'(n), 32'd256, "dumped head lines");
        watch(2200, 1'b0, 2'b00, d);
        chk32(32'(d), 32'd0, "offset held at black");
        $display("test fast dump done");
        // ch0 below black, ch1 above: two corrections each, then quiet
        restart();
        {code0, code1} <= {12'hfee, 12'hff2};
        repeat (2) @(posedge clk_sys);
        load <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h0000_0075);
        @(posedge clk_sys iff xfer_gate === 1'b1);
        watch(3 * LINE_DUAL, 1'b1, 2'b01, d);
        chk1(d > 0, 1'b1, "offset corrected");
        watch(2 * LINE_DUAL, 1'b1, 2'b00, d);
        chk32(32'(d), 32'd0, "offset settled");
        $display("test offset loop done");
        final_report();
    end
endmodule
`default_nettype wire
